//--- rtl/uart_msfc_map.svh
// register offsets, field positions and reset values of the modem status and flow control block
`ifndef UART_MSFC_MAP_SVH
`define UART_MSFC_MAP_SVH

`define MSFC_ADDR_W        4
`define MSFC_ADDR_MLS      4'h0
`define MSFC_ADDR_SCRATCH  4'h1
`define MSFC_ADDR_EFC      4'h2
`define MSFC_ADDR_IEM      4'h3
`define MSFC_ADDR_ISS      4'h4
`define MSFC_ADDR_FIFO     4'h5
`define MSFC_ADDR_MOC      4'h6
`define MSFC_ADDR_CHAR0    4'h7
`define MSFC_ADDR_CHARN    4'hA

`define MSFC_CHAR_RESUME1  2'h0
`define MSFC_CHAR_RESUME2  2'h1
`define MSFC_CHAR_PAUSE1   2'h2
`define MSFC_CHAR_PAUSE2   2'h3

`define EFC_AUTO_CTS       7
`define EFC_AUTO_RTS       6
`define EFC_SPECIAL        5
`define EFC_ENHANCED       4

`define IEM_ENH_MASK       8'hF0
`define ISS_ENH_MASK       8'h30
`define FIFO_ENH_MASK      8'h30
`define MOC_ENH_MASK       8'hE0
`define ISS_SPECIAL_BIT    4
`define ISS_NO_IRQ_BIT     0

`define MOC_DTR_BIT        0
`define MOC_RTS_BIT        1
`define MOC_OUT1_BIT       2
`define MOC_OUT2_BIT       3
`define MOC_LOOP_BIT       4

`define DELTA_CTS          0
`define DELTA_DSR          1
`define DELTA_RI           2
`define DELTA_CD           3

`define RX_LEVEL_W         7
`define RX_LVL_EMPTY       7'h01
`define RX_LVL_TRIG0       7'h08
`define RX_LVL_TRIG1       7'h10
`define RX_LVL_TRIG2       7'h38
`define RX_LVL_TRIG3       7'h3C
`define RX_LVL_FULL        7'h40

`define REG_RESET          8'h00

`endif

//--- rtl/uart_msfc_pkg.sv
// types shared by the modem status and flow control block
package uart_msfc_pkg;

  typedef logic [3:0][7:0] flow_chars_t;

  typedef enum logic [1:0] {
    MATCH_IDLE     = 2'b00,
    MATCH_ON_HALF  = 2'b01,
    MATCH_OFF_HALF = 2'b11
  } match_state_t;

  typedef struct packed {
    match_state_t st;
  } match_regs_t;

  typedef struct packed {
    logic [3:0]  line_prev;
    logic        seeded;
    logic [3:0]  delta;
    logic [7:0]  scratch;
    logic [7:0]  efc;
    logic [7:0]  iem;
    logic [1:0]  iss_enh;
    logic [7:0]  fifo;
    logic [7:0]  moc;
    flow_chars_t chars;
    logic [7:0]  rdata;
    logic        msi_irq;
    logic        trig_irq;
    logic        rts_stop;
    logic        rts_n;
    logic        cts_halt;
    logic        sw_hold;
    logic        tx_allowed;
  } main_regs_t;

endpackage

//--- rtl/flow_char_bus_if.sv
// signals between the register side and the received-character matcher
`timescale 1ns/1ns
interface flow_char_bus_if;
  logic                        rx_valid;
  logic [7:0]                  rx_data;
  logic [1:0]                  rx_mode;
  logic                        special_en;
  uart_msfc_pkg::flow_chars_t  chars;
  logic                        xon_hit;
  logic                        xoff_hit;
  logic                        special_hit;

  modport ctrl (output rx_valid, output rx_data, output rx_mode, output special_en, output chars,
                input xon_hit, input xoff_hit, input special_hit);
  modport matcher (input rx_valid, input rx_data, input rx_mode, input special_en, input chars,
                   output xon_hit, output xoff_hit, output special_hit);
endinterface

//--- rtl/flow_char_match.sv
// compares received characters with the stored flow-control characters
`timescale 1ns/1ns
`include "uart_msfc_map.svh"
module flow_char_match (
  input  wire logic       core_clk,
  input  wire logic       rst,
  flow_char_bus_if.matcher fb
);

  uart_msfc_pkg::match_regs_t s_q;
  uart_msfc_pkg::match_regs_t s_d;

  function automatic logic is_char(input logic [7:0] d, input logic [7:0] c);
    is_char = (d == c); // (R12)
  endfunction

  logic [7:0] on_c;
  logic [7:0] off_c;
  logic       dual;

  always_comb begin
    s_d            = s_q;
    fb.xon_hit     = 1'b0;
    fb.xoff_hit    = 1'b0;
    fb.special_hit = fb.rx_valid && fb.special_en && is_char(fb.rx_data, fb.chars[`MSFC_CHAR_PAUSE2]); // (R11)
    dual           = (fb.rx_mode == 2'b11);
    on_c           = fb.rx_mode[0] ? fb.chars[`MSFC_CHAR_RESUME2] : fb.chars[`MSFC_CHAR_RESUME1]; // (R17)
    off_c          = fb.rx_mode[0] ? fb.chars[`MSFC_CHAR_PAUSE2] : fb.chars[`MSFC_CHAR_PAUSE1];
    if (fb.rx_valid && fb.rx_mode != 2'b00) begin
      if (!dual) begin
        fb.xon_hit  = is_char(fb.rx_data, on_c);
        fb.xoff_hit = is_char(fb.rx_data, off_c);
        s_d.st      = uart_msfc_pkg::MATCH_IDLE;
      end else begin
        // pairs must arrive back to back, first character then second
        case (s_q.st)
          uart_msfc_pkg::MATCH_ON_HALF: begin
            fb.xon_hit = is_char(fb.rx_data, fb.chars[`MSFC_CHAR_RESUME2]); // (R18)
          end
          uart_msfc_pkg::MATCH_OFF_HALF: begin
            fb.xoff_hit = is_char(fb.rx_data, fb.chars[`MSFC_CHAR_PAUSE2]); // (R18)
          end
          default: begin
          end
        endcase
        if (is_char(fb.rx_data, fb.chars[`MSFC_CHAR_RESUME1])) begin
          s_d.st = uart_msfc_pkg::MATCH_ON_HALF;
        end else if (is_char(fb.rx_data, fb.chars[`MSFC_CHAR_PAUSE1])) begin
          s_d.st = uart_msfc_pkg::MATCH_OFF_HALF;
        end else begin
          s_d.st = uart_msfc_pkg::MATCH_IDLE;
        end
      end
    end else if (fb.rx_mode != 2'b11) begin
      s_d.st = uart_msfc_pkg::MATCH_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.st <= uart_msfc_pkg::MATCH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // flow_char_match

//--- rtl/uart_modem_status_flow_control.sv
// modem status change tracking, scratch byte and enhanced flow control of one uart channel
// Operation
// (R1) dsr and cts delta bits set when that input changed since last status read
// (R2) any of the four delta bits raises the modem status interrupt
// (R3) reading the modem line status clears all four delta bits
// (R4) eight-bit scratch byte, host read and write, no effect on the channel
// (R5) auto cts: halt transmit while cts pin high, resume when low
// (R6) the character being shifted out finishes before cts halts transmit
// (R7) auto rts: interrupt when receive fifo reaches programmed trigger level
// (R8) auto rts: rts pin goes high at the next trigger level above
// (R9) auto rts: rts pin returns low below the next lower trigger level
// (R10) without hardware flow control rts pin follows its modem control bit
// (R11) special detect compares each received character with second pause character, sets status bit
// (R12) bit 0 of stored characters matches least significant received bit
// (R13) host clears software flow selection before enabling special detect
// (R14) enhanced bit set lets writes reach the enhanced register fields
// (R15) enhanced bit clear latches those fields against further writes
// (R16) enhanced bits 3-0 pick the software flow-control combination
// (R17) bits 3-2 pick transmitted pairs, bits 1-0 pick compared pairs
// (R18) dual mode treats two characters as one ordered sequence
// (R19) reset clears every enhanced feature bit
// (R20) host never sends the flow characters as payload under software flow control
// (R21) modem status interrupt stays until a status read clears the deltas
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "uart_msfc_map.svh"
module uart_modem_status_flow_control (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [`MSFC_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    cts_n,
  input  wire logic                    dsr_n,
  input  wire logic                    ri_n,
  input  wire logic                    cd_n,
  input  wire logic [`RX_LEVEL_W-1:0]  rx_fifo_level,
  input  wire logic                    rx_char_valid,
  input  wire logic [7:0]              rx_char,
  input  wire logic                    tx_char_busy,
  output logic                         rts_n,
  output logic                         tx_allowed,
  output logic                         modem_status_irq,
  output logic                         rx_trigger_irq,
  output logic                         special_char_irq,
  output logic      [1:0]              tx_pair_sel
);

  uart_msfc_pkg::main_regs_t s_q;
  uart_msfc_pkg::main_regs_t s_d;

  flow_char_bus_if fb ();

  flow_char_match u_match (
    .core_clk (core_clk),
    .rst      (rst),
    .fb       (fb.matcher)
  );

  function automatic logic is_char_addr(input logic [`MSFC_ADDR_W-1:0] a);
    is_char_addr = (a >= `MSFC_ADDR_CHAR0) && (a <= `MSFC_ADDR_CHARN);
  endfunction

  // keeps locked bits, lets the rest take the new value
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] enh, input logic unlocked);
    merge = unlocked ? new_v : ((old_v & enh) | (new_v & ~enh));
  endfunction

  // index 0 is the empty floor, 5 the full ceiling, 1..4 the programmable triggers
  function automatic logic [`RX_LEVEL_W-1:0] trig_level(input logic [2:0] idx);
    case (idx)
      3'h0:    trig_level = `RX_LVL_EMPTY;
      3'h1:    trig_level = `RX_LVL_TRIG0;
      3'h2:    trig_level = `RX_LVL_TRIG1;
      3'h3:    trig_level = `RX_LVL_TRIG2;
      3'h4:    trig_level = `RX_LVL_TRIG3;
      default: trig_level = `RX_LVL_FULL;
    endcase
  endfunction

  // line state as seen by the status bits, looped from modem control in loop-back
  logic [3:0] line_now;
  always_comb begin
    if (s_q.moc[`MOC_LOOP_BIT]) begin
      line_now = {s_q.moc[`MOC_OUT2_BIT], s_q.moc[`MOC_OUT1_BIT], s_q.moc[`MOC_DTR_BIT], s_q.moc[`MOC_RTS_BIT]};
    end else begin
      line_now = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
    end
  end

  logic [3:0] line_change;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_delta
      if (gi == `DELTA_RI) begin : g_trail
        // ring indicator counts only the pin going from low to high
        assign line_change[gi] = s_q.seeded & s_q.line_prev[gi] & ~line_now[gi];
      end else begin : g_any
        assign line_change[gi] = s_q.seeded & (s_q.line_prev[gi] ^ line_now[gi]); // (R1)
      end
    end
  endgenerate

  logic [2:0]                prog_idx;
  logic [`RX_LEVEL_W-1:0]    lvl_prog;
  logic [`RX_LEVEL_W-1:0]    lvl_up;
  logic [`RX_LEVEL_W-1:0]    lvl_down;
  logic                      unlocked;
  logic [1:0]                char_idx;
  logic [7:0]                iss_view;

  assign prog_idx = {1'b0, s_q.fifo[7:6]} + 3'h1;
  assign lvl_prog = trig_level(prog_idx);
  assign lvl_up   = trig_level(prog_idx + 3'h1);
  assign lvl_down = trig_level(prog_idx - 3'h1);
  assign unlocked = s_q.efc[`EFC_ENHANCED];
  assign char_idx = 2'(reg_addr - `MSFC_ADDR_CHAR0);

  always_comb begin
    iss_view                   = 8'h00;
    iss_view[5:4]              = s_q.iss_enh;
    iss_view[`ISS_NO_IRQ_BIT]  = ~(s_q.msi_irq | s_q.trig_irq | s_q.iss_enh[0]);
  end

  assign fb.rx_valid   = rx_char_valid;
  assign fb.rx_data    = rx_char;
  assign fb.rx_mode    = s_q.efc[1:0]; // (R16)
  assign fb.special_en = s_q.efc[`EFC_SPECIAL];
  assign fb.chars      = s_q.chars;

  always_comb begin
    s_d           = s_q;
    s_d.rdata     = 8'h00;
    s_d.seeded    = 1'b1;
    s_d.line_prev = line_now;

    // a change in the read cycle survives the clear
    if (reg_rd && reg_addr == `MSFC_ADDR_MLS) begin
      s_d.delta = line_change; // (R3)
    end else begin
      s_d.delta = s_q.delta | line_change; // (R1)
    end
    s_d.msi_irq = |s_d.delta; // (R2) (R21)

    // register writes
    if (reg_wr) begin
      if (reg_addr == `MSFC_ADDR_SCRATCH) begin
        s_d.scratch = reg_wdata; // (R4)
      end else if (reg_addr == `MSFC_ADDR_EFC) begin
        s_d.efc = reg_wdata;
      end else if (reg_addr == `MSFC_ADDR_IEM) begin
        s_d.iem = merge(s_q.iem, reg_wdata, `IEM_ENH_MASK, unlocked); // (R14) (R15)
      end else if (reg_addr == `MSFC_ADDR_ISS) begin
        if (unlocked) begin
          s_d.iss_enh = reg_wdata[5:4]; // (R14) (R15)
        end
      end else if (reg_addr == `MSFC_ADDR_FIFO) begin
        s_d.fifo = merge(s_q.fifo, reg_wdata, `FIFO_ENH_MASK, unlocked); // (R14) (R15)
      end else if (reg_addr == `MSFC_ADDR_MOC) begin
        s_d.moc = merge(s_q.moc, reg_wdata, `MOC_ENH_MASK, unlocked); // (R14) (R15)
      end else if (is_char_addr(reg_addr)) begin
        s_d.chars[char_idx] = reg_wdata;
      end
    end

    // special character flag: read of the status clears it, a new match wins
    if (reg_rd && reg_addr == `MSFC_ADDR_ISS) begin
      s_d.iss_enh[0] = 1'b0;
    end
    if (fb.special_hit) begin
      s_d.iss_enh[0] = 1'b1; // (R11)
    end

    // register reads, answered one cycle later
    if (reg_rd) begin
      if (reg_addr == `MSFC_ADDR_MLS) begin
        s_d.rdata = {line_now, s_q.delta};
      end else if (reg_addr == `MSFC_ADDR_SCRATCH) begin
        s_d.rdata = s_q.scratch; // (R4)
      end else if (reg_addr == `MSFC_ADDR_EFC) begin
        s_d.rdata = s_q.efc;
      end else if (reg_addr == `MSFC_ADDR_IEM) begin
        s_d.rdata = s_q.iem;
      end else if (reg_addr == `MSFC_ADDR_ISS) begin
        s_d.rdata = iss_view;
      end else if (reg_addr == `MSFC_ADDR_FIFO) begin
        s_d.rdata = s_q.fifo;
      end else if (reg_addr == `MSFC_ADDR_MOC) begin
        s_d.rdata = s_q.moc;
      end else if (is_char_addr(reg_addr)) begin
        s_d.rdata = s_q.chars[char_idx];
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // hardware receive flow control with hysteresis between two trigger levels
    if (s_q.efc[`EFC_AUTO_RTS]) begin
      s_d.trig_irq = (rx_fifo_level >= lvl_prog); // (R7)
      if (rx_fifo_level >= lvl_up) begin
        s_d.rts_stop = 1'b1; // (R8)
      end else if (rx_fifo_level < lvl_down) begin
        s_d.rts_stop = 1'b0; // (R9)
      end
      s_d.rts_n = s_d.rts_stop; // (R8) (R9)
    end else begin
      s_d.trig_irq = 1'b0;
      s_d.rts_stop = 1'b0;
      s_d.rts_n    = ~s_q.moc[`MOC_RTS_BIT]; // (R10)
    end

    // clear-to-send halt waits for the shifting character to finish
    if (s_q.efc[`EFC_AUTO_CTS] && !line_now[`DELTA_CTS]) begin
      s_d.cts_halt = s_q.cts_halt || !tx_char_busy; // (R5) (R6)
    end else begin
      s_d.cts_halt = 1'b0; // (R5)
    end

    // received pause and resume characters gate the transmitter
    if (s_q.efc[1:0] == 2'b00) begin
      s_d.sw_hold = 1'b0;
    end else if (fb.xoff_hit) begin
      s_d.sw_hold = 1'b1; // (R16) (R17)
    end else if (fb.xon_hit) begin
      s_d.sw_hold = 1'b0; // (R16) (R17)
    end

    s_d.tx_allowed = ~s_d.cts_halt & ~s_d.sw_hold;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.line_prev  <= 4'h0;
      s_q.seeded     <= 1'b0;
      s_q.delta      <= 4'h0;
      s_q.scratch    <= `REG_RESET;
      s_q.efc        <= `REG_RESET; // (R19)
      s_q.iem        <= `REG_RESET;
      s_q.iss_enh    <= 2'h0;
      s_q.fifo       <= `REG_RESET;
      s_q.moc        <= `REG_RESET;
      s_q.chars      <= '0;
      s_q.rdata      <= 8'h00;
      s_q.msi_irq    <= 1'b0;
      s_q.trig_irq   <= 1'b0;
      s_q.rts_stop   <= 1'b0;
      s_q.rts_n      <= 1'b1;
      s_q.cts_halt   <= 1'b0;
      s_q.sw_hold    <= 1'b0;
      s_q.tx_allowed <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata        = s_q.rdata;
  assign rts_n            = s_q.rts_n;
  assign tx_allowed       = s_q.tx_allowed;
  assign modem_status_irq = s_q.msi_irq;
  assign rx_trigger_irq   = s_q.trig_irq;
  assign special_char_irq = s_q.iss_enh[0];
  assign tx_pair_sel      = s_q.efc[3:2]; // (R17)

endmodule // uart_modem_status_flow_control

//--- testbench/msfc_monitor.sv
// assertion checker for the modem status and flow control block
`timescale 1ns/1ns
`include "uart_msfc_map.svh"
module msfc_monitor (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic [`MSFC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    cts_n,
  input wire logic                    dsr_n,
  input wire logic                    ri_n,
  input wire logic                    cd_n,
  input wire logic [`RX_LEVEL_W-1:0]  rx_fifo_level,
  input wire logic                    rx_char_valid,
  input wire logic [7:0]              rx_char,
  input wire logic                    tx_char_busy,
  input wire logic                    rts_n,
  input wire logic                    tx_allowed,
  input wire logic                    modem_status_irq,
  input wire logic                    rx_trigger_irq,
  input wire logic                    special_char_irq,
  input wire logic [1:0]              tx_pair_sel
);
  logic [7:0] efc_q;
  logic [7:0] pause2_q;
  logic [1:0] trig_q;
  // shadows of the writable fields the checks depend on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      efc_q <= 8'h00;
      pause2_q <= 8'h00;
      trig_q <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == `MSFC_ADDR_EFC) efc_q <= reg_wdata;
      if (reg_addr == `MSFC_ADDR_CHARN) pause2_q <= reg_wdata;
      if (reg_addr == `MSFC_ADDR_FIFO) trig_q <= reg_wdata[7:6];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_line_delta: assert property (!$past(rst) && !($stable(cts_n) && $stable(dsr_n)) |=> modem_status_irq)
    else $error("modem status irq missing after line change");
  a_read_clears: assert property (reg_rd && reg_addr == `MSFC_ADDR_MLS && $stable(cts_n) && $stable(dsr_n)
    && $stable(ri_n) && $stable(cd_n) |=> !modem_status_irq) else $error("status read left irq set");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_cts_halt: assert property (efc_q[`EFC_AUTO_CTS] && cts_n && !tx_char_busy |=> !tx_allowed)
    else $error("transmit not halted by cts");
  a_cts_finish: assert property (efc_q[`EFC_AUTO_CTS] && efc_q[3:0] == 4'h0 && tx_char_busy && tx_allowed
    |=> tx_allowed) else $error("character cut short by cts");
  a_cts_resume: assert property (efc_q[`EFC_AUTO_CTS] && efc_q[3:0] == 4'h0 && !cts_n |=> tx_allowed)
    else $error("transmit not resumed");
  a_trig_irq: assert property (efc_q[`EFC_AUTO_RTS] && trig_q == 2'h0 && rx_fifo_level >= 7'h08
    |=> rx_trigger_irq) else $error("trigger irq missing");
  a_rts_raise: assert property (efc_q[`EFC_AUTO_RTS] && trig_q == 2'h0 && rx_fifo_level >= 7'h10 |=> rts_n)
    else $error("rts not raised");
  a_rts_release: assert property (efc_q[`EFC_AUTO_RTS] && rx_fifo_level == 7'h00 |=> !rts_n)
    else $error("rts not released");
  a_pair_sel: assert property ($stable(efc_q) |-> tx_pair_sel == efc_q[3:2])
    else $error("pair select differs from control");
  a_special: assert property (efc_q[`EFC_SPECIAL] && rx_char_valid && rx_char == pause2_q
    |=> special_char_irq) else $error("special character missed");
endmodule // msfc_monitor
bind uart_modem_status_flow_control msfc_monitor u_mon (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .cts_n, .dsr_n, .ri_n, .cd_n, .rx_fifo_level, .rx_char_valid, .rx_char, .tx_char_busy, .rts_n,
  .tx_allowed, .modem_status_irq, .rx_trigger_irq, .special_char_irq, .tx_pair_sel);

//--- testbench/modem_peer.sv
// modem at the far side of the handshake lines
`timescale 1ns/1ns
module modem_peer (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] assert_req,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            cd_n
);
  // lines move just after an edge, like a modem synchronised to the port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {cd_n, ri_n, dsr_n, cts_n} <= 4'hF;
    end else begin
      {cd_n, ri_n, dsr_n, cts_n} <= ~assert_req;
    end
  end
endmodule // modem_peer

//--- testbench/uart_modem_status_flow_control_bench.sv
// self-checking bench for the modem status and flow control block
`timescale 1ns/1ns
`include "uart_msfc_map.svh"
module uart_modem_status_flow_control_bench;
  logic                    core_clk = 1'b0;
  logic                    rst = 1'b1;
  logic [`MSFC_ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [7:0]              reg_rdata;
  logic                    cts_n, dsr_n, ri_n, cd_n;
  logic [3:0]              want = 4'h0;
  logic [`RX_LEVEL_W-1:0]  lvl = 7'h00;
  logic                    rx_char_valid = 1'b0;
  logic [7:0]              rx_char = 8'h00;
  logic                    busy = 1'b0;
  logic                    rts_n, tx_allowed, ms_irq, trig_irq, sp_irq;
  logic [1:0]              tx_pair_sel;
  logic [7:0]              v;
  int                      n_fail = 0;
  int                      total_checks = 0;

  always #10 core_clk = ~core_clk;

  modem_peer peer (.core_clk(core_clk), .rst(rst), .assert_req(want), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n));
  uart_modem_status_flow_control dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .rx_fifo_level(lvl), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_char_busy(busy), .rts_n(rts_n), .tx_allowed(tx_allowed),
    .modem_status_irq(ms_irq), .rx_trigger_irq(trig_irq), .special_char_irq(sp_irq), .tx_pair_sel(tx_pair_sel));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic r(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rx(input logic [7:0] c);
    @(posedge core_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge core_clk);
    rx_char_valid <= 1'b0;
  endtask
  task automatic t_reset();
    chk("rts_n", 8'h01, {7'h00, rts_n});
    chk("tx_allowed", 8'h01, {7'h00, tx_allowed});
    r(`MSFC_ADDR_EFC, v);
    chk("efc", 8'h00, v);
  endtask
  task automatic t_scratch();
    w(`MSFC_ADDR_SCRATCH, 8'hA5);
    r(`MSFC_ADDR_SCRATCH, v);
    chk("scratch", 8'hA5, v);
    w(`MSFC_ADDR_SCRATCH, 8'h5A);
    w(4'hF, 8'hFF);
    r(4'hF, v);
    chk("unmapped", 8'h00, v);
    r(`MSFC_ADDR_SCRATCH, v);
    chk("scratch", 8'h5A, v);
  endtask
  task automatic t_modem();
    logic [3:0] req [4] = '{4'b0001, 4'b0011, 4'b1100, 4'b0000};
    logic [7:0] exp [4] = '{8'h11, 8'h32, 8'hCB, 8'h0C};
    foreach (req[i]) begin
      @(posedge core_clk);
      want <= req[i];
      wt(2);
      chk("ms_irq", 8'h01, {7'h00, ms_irq});
      r(`MSFC_ADDR_MLS, v);
      chk("line state", exp[i], v);
      chk("ms_irq", 8'h00, {7'h00, ms_irq});
    end
    r(`MSFC_ADDR_MLS, v);
    chk("line state", 8'h00, v);
    w(`MSFC_ADDR_MOC, 8'h13);
    r(`MSFC_ADDR_MLS, v);
    chk("loop line state", 8'h33, v);
    w(`MSFC_ADDR_MOC, 8'h00);
    r(`MSFC_ADDR_MLS, v);
    chk("loop line state", 8'h03, v);
  endtask
  task automatic t_auto_cts();
    @(posedge core_clk);
    busy <= 1'b1;
    w(`MSFC_ADDR_EFC, 8'h80);
    wt(2);
    chk("tx_allowed", 8'h01, {7'h00, tx_allowed});
    @(posedge core_clk);
    busy <= 1'b0;
    wt(2);
    chk("tx_allowed", 8'h00, {7'h00, tx_allowed});
    @(posedge core_clk);
    want <= 4'b0001;
    wt(3);
    chk("tx_allowed", 8'h01, {7'h00, tx_allowed});
    w(`MSFC_ADDR_EFC, 8'h00);
  endtask
  task automatic t_auto_rts();
    logic [6:0] l [8] = '{7'h07, 7'h08, 7'h10, 7'h01, 7'h00, 7'h10, 7'h38, 7'h07};
    logic [1:0] e [8] = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b11, 2'b00};
    w(`MSFC_ADDR_EFC, 8'h40);
    foreach (l[i]) begin
      if (i == 5) w(`MSFC_ADDR_FIFO, 8'h40);
      @(posedge core_clk);
      lvl <= l[i];
      wt(2);
      chk("trig_irq rts_n", {6'h00, e[i]}, {6'h00, trig_irq, rts_n});
    end
    w(`MSFC_ADDR_EFC, 8'h00);
    for (int k = 0; k < 2; k++) begin
      w(`MSFC_ADDR_MOC, k[0] ? 8'h00 : 8'h02);
      wt(2);
      chk("rts_n", {7'h00, k[0]}, {7'h00, rts_n});
    end
  endtask
  task automatic t_special();
    w(`MSFC_ADDR_CHARN, 8'h13);
    w(`MSFC_ADDR_EFC, 8'h20);
    rx(8'h12);
    wt(2);
    chk("sp_irq", 8'h00, {7'h00, sp_irq});
    rx(8'h13);
    wt(2);
    chk("sp_irq", 8'h01, {7'h00, sp_irq});
    r(`MSFC_ADDR_ISS, v);
    chk("iss bit4", 8'h01, {7'h00, v[4]});
    w(`MSFC_ADDR_EFC, 8'h00);
  endtask
  task automatic t_lock();
    w(`MSFC_ADDR_EFC, 8'h10);
    w(`MSFC_ADDR_IEM, 8'hF0);
    r(`MSFC_ADDR_IEM, v);
    chk("iem", 8'hF0, v);
    w(`MSFC_ADDR_EFC, 8'h00);
    w(`MSFC_ADDR_IEM, 8'h0F);
    r(`MSFC_ADDR_IEM, v);
    chk("iem", 8'hFF, v);
  endtask
  task automatic t_swflow();
    logic [7:0] s [7] = '{8'h13, 8'h14, 8'h11, 8'h12, 8'h13, 8'h55, 8'h14};
    logic       e [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int k = 0; k < 4; k++) begin
      w(`MSFC_ADDR_EFC, {4'h0, k[1:0], 2'b00});
      wt(2);
      chk("tx_pair_sel", {6'h00, k[1:0]}, {6'h00, tx_pair_sel});
    end
    for (int k = 0; k < 4; k++) w(`MSFC_ADDR_CHAR0 + 4'(k), 8'h11 + 8'(k));
    w(`MSFC_ADDR_EFC, 8'h03);
    foreach (s[i]) begin
      rx(s[i]);
      wt(2);
      chk("tx_allowed", {7'h00, e[i]}, {7'h00, tx_allowed});
    end
    w(`MSFC_ADDR_EFC, 8'h02);
    rx(8'h13);
    wt(2);
    chk("tx_allowed", 8'h00, {7'h00, tx_allowed});
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wt(1);
    t_reset();
    t_scratch();
    t_modem();
    t_auto_cts();
    t_auto_rts();
    t_special();
    t_lock();
    t_swflow();
    end_of_test();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule // uart_modem_status_flow_control_bench
